// >>> design/tas_cfg.svh
// Purpose: constants of the thermal alert status and mask register bank
// Assumes: one clock, synchronous active-high reset, word-per-register APB map
// Notes: printed offsets are register indexes; byte address is four times that
// Function
// - extra cpu readings out of limit set bits 3-5
// - current monitor out of window sets bit 6
// - termination voltage out of window sets bit 7
// - status read clears only subsided bits; 2:0 reserved
// - mask three bit 0 blocks first cpu alerts
// - mask three bit 1 blocks cpu data errors
// - mask three bit 2 blocks cpu link errors
// - mask three bit 3 blocks thermal pin overtemperature
// - mask three bit 7 blocks summary, independent
// - mask four bits 3-5 block cpu readings 2-4
// - mask four bits 6,7 block monitor, voltage
// - low limits reset 00, high limits ff
// - lock bit makes limits, config, points read-only
// - domain bits 5-3 give cpu 2-4 domains
// - cpu count field selects one to four cpus
// - operating points reset fb, then 64 each
// - enabled operating point is channel target temperature
// - thermal pin with capture enable copies temperature
// - bypass scale maps 00-ff onto 0-2.25 V
`ifndef TAS_CFG_SVH
`define TAS_CFG_SVH

`define TAS_IDX_STATUS_FOUR    8'h81
`define TAS_IDX_MASK_THREE     8'h82
`define TAS_IDX_MASK_FOUR      8'h83
`define TAS_IDX_TV_LOW         8'h84
`define TAS_IDX_CM_LOW         8'h85
`define TAS_IDX_TV_HIGH        8'h86
`define TAS_IDX_CM_HIGH        8'h87
`define TAS_IDX_CPU_CFG_TWO    8'h88
`define TAS_IDX_OP_CPU         8'h8a
`define TAS_IDX_OP_REMOTE_ONE  8'h8b
`define TAS_IDX_OP_LOCAL       8'h8c
`define TAS_IDX_OP_REMOTE_TWO  8'h8d

`define TAS_RST_STATUS         8'h00
`define TAS_RST_MASK           8'h00
`define TAS_RST_LOW_LIMIT      8'h00
`define TAS_RST_HIGH_LIMIT     8'hff
`define TAS_RST_CPU_CFG        8'h00
`define TAS_RST_OP_CPU         8'hfb
`define TAS_RST_OP_TEMP        8'h64

`define TAS_STATUS_USED        8'hf8
`define TAS_BIT_CPU1           3
`define TAS_BIT_CPU3           5
`define TAS_BIT_CURRENT_MON    6
`define TAS_BIT_TERM_VOLT      7
`define TAS_BIT_M3_CPU0        0
`define TAS_BIT_M3_DATA        1
`define TAS_BIT_M3_LINK        2
`define TAS_BIT_M3_OVERTEMP    3
`define TAS_BIT_M3_SUMMARY     7
`define TAS_BIT_DOM_CPU4       3
`define TAS_BIT_DOM_CPU3       4
`define TAS_BIT_DOM_CPU2       5
`define TAS_FLD_CPU_COUNT_HI   7
`define TAS_FLD_CPU_COUNT_LO   6

`define TAS_CPU_BASE_ADDR      8'h30
`define TAS_BYPASS_FULL_MV     12'd2250
`define TAS_CODE_FULL          8'hff

`endif

// >>> design/tas_pkg.sv
// Purpose: shared types of the thermal alert register bank
// Assumes: 8-bit register contents
// Notes: none
package tas_pkg;

	typedef logic [7:0] tas_byte_t;

	typedef struct packed {
		tas_byte_t low;
		tas_byte_t high;
	} tas_window_s;

	typedef struct packed {
		tas_byte_t cpu;
		tas_byte_t remote_one;
		tas_byte_t on_die;
		tas_byte_t remote_two;
	} tas_op_points_s;

	typedef struct packed {
		logic       cpu_zero_out_of_limit;
		logic       data_error;
		logic       link_error;
		logic       overtemp;
		logic [3:1] cpu_out_of_limit;
	} tas_events_s;

	typedef struct packed {
		logic remote_one;
		logic on_die;
		logic remote_two;
	} tas_channel_flags_s;

endpackage

// >>> design/tas_window_check.sv
// Purpose: tells whether a reading lies outside its low/high window
// Assumes: unsigned codes, window edges themselves count as inside
// Notes: purely combinational
module tas_window_check (
	input  tas_pkg::tas_byte_t    reading,
	input  tas_pkg::tas_window_s  window,
	output logic                  outside
);

	always_comb begin
		outside = (reading > window.high) || (reading < window.low);
	end

endmodule

// >>> design/tas_sticky_status.sv
// Purpose: sticky status bits cleared by a read only once the cause has gone
// Assumes: clear vector names the bits that the read returned
// Notes: a cause present in the clearing cycle keeps its bit set
`include "tas_cfg.svh"

module tas_sticky_status (
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic [7:0]    cause,
	input  wire logic [7:0]    read_clear,
	output tas_pkg::tas_byte_t status
);

	tas_pkg::tas_byte_t next_status;

	always_comb begin
		// set wins over clear: a live cause reasserts the bit
		next_status = ((status & ~read_clear) | cause) & `TAS_STATUS_USED;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			status <= `TAS_RST_STATUS;
		end else begin
			status <= next_status;
		end
	end

endmodule

// >>> design/tas_regs.sv
// Purpose: APB register bank for thermal alert status, masks, limits and operating points
// Assumes: measurement, cpu link and fan loop live outside; inputs are synchronous to mclk
// Notes: zero-wait APB slave; read data is prepared in the setup cycle
`include "tas_cfg.svh"

module tas_regs (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 config_lock,
	input  tas_pkg::tas_events_s      events,
	input  tas_pkg::tas_byte_t        current_monitor,
	input  tas_pkg::tas_byte_t        termination_voltage,
	input  wire logic                 term_voltage_bypass,
	input  wire logic                 thermal_limit_pin,
	input  tas_pkg::tas_channel_flags_s capture_enable,
	input  tas_pkg::tas_channel_flags_s fan_start_temperature_dynamic,
	input  wire logic                 cpu_dynamic_enable,
	input  tas_pkg::tas_byte_t        remote_one_temp,
	input  tas_pkg::tas_byte_t        local_temp,
	input  tas_pkg::tas_byte_t        remote_two_temp,
	output logic                      alert,
	output logic                      out_of_limit_summary,
	output logic      [3:0]           cpu_poll_enable,
	output logic      [3:0]           cpu_two_domains,
	output tas_pkg::tas_op_points_s   target_temp,
	output logic      [4:0]           target_valid,
	output logic      [11:0]          term_voltage_mv,
	output logic                      term_voltage_mv_valid
);

	tas_pkg::tas_byte_t      limit_event_status_four;
	tas_pkg::tas_byte_t      alert_mask_three;
	tas_pkg::tas_byte_t      alert_mask_four;
	tas_pkg::tas_window_s    term_voltage_limits;
	tas_pkg::tas_window_s    current_mon_limits;
	tas_pkg::tas_byte_t      cpu_link_config_two;
	tas_pkg::tas_op_points_s op_point;

	logic [9:0]              reg_index;
	logic                    setup_phase;
	logic                    access_done;
	logic                    wr_en;
	logic                    wr_allowed;
	logic                    index_mapped;
	tas_pkg::tas_byte_t      read_value;
	tas_pkg::tas_byte_t      read_snapshot;
	logic                    snapshot_is_status;
	tas_pkg::tas_byte_t      status_cause;
	tas_pkg::tas_byte_t      status_clear;
	logic                    current_mon_outside;
	logic                    term_voltage_outside;
	logic                    thermal_limit_pin_prev;
	logic                    thermal_limit_pin_rise;
	logic [3:0]              cpu_active;
	logic                    alert_from_status;
	logic                    alert_from_events;

	// index decode shared by read and write paths
	function automatic logic is_locked_index(input logic [9:0] idx);
		logic locked;
		locked = 1'b0;
		case (idx)
			{2'b00, `TAS_IDX_TV_LOW},
			{2'b00, `TAS_IDX_CM_LOW},
			{2'b00, `TAS_IDX_TV_HIGH},
			{2'b00, `TAS_IDX_CM_HIGH},
			{2'b00, `TAS_IDX_CPU_CFG_TWO},
			{2'b00, `TAS_IDX_OP_CPU},
			{2'b00, `TAS_IDX_OP_REMOTE_ONE},
			{2'b00, `TAS_IDX_OP_LOCAL},
			{2'b00, `TAS_IDX_OP_REMOTE_TWO}: begin
				locked = 1'b1;
			end
			default: begin
				locked = 1'b0;
			end
		endcase
		return locked;
	endfunction

	function automatic logic is_index(input logic [9:0] idx, input logic [7:0] want);
		return idx == {2'b00, want};
	endfunction

	// cpu n is polled when the count field reaches n minus one
	function automatic logic [3:0] cpus_from_count(input logic [1:0] count);
		logic [3:0] en;
		en = 4'h0;
		case (count)
			2'b00: begin
				en = 4'h1;
			end
			2'b01: begin
				en = 4'h3;
			end
			2'b10: begin
				en = 4'h7;
			end
			2'b11: begin
				en = 4'hf;
			end
			default: begin
				en = 4'h1;
			end
		endcase
		return en;
	endfunction

	assign reg_index   = paddr[11:2];
	assign setup_phase = psel && !penable;
	assign pready      = 1'b1;
	assign access_done = psel && penable && pready;
	assign wr_en       = access_done && pwrite && (paddr[1:0] == 2'b00);
	assign wr_allowed  = wr_en && !(config_lock && is_locked_index(reg_index));

	always_comb begin
		index_mapped = 1'b1;
		read_value   = 8'h00;
		case (reg_index)
			{2'b00, `TAS_IDX_STATUS_FOUR}: begin
				read_value = limit_event_status_four;
			end
			{2'b00, `TAS_IDX_MASK_THREE}: begin
				read_value = alert_mask_three;
			end
			{2'b00, `TAS_IDX_MASK_FOUR}: begin
				read_value = alert_mask_four;
			end
			{2'b00, `TAS_IDX_TV_LOW}: begin
				read_value = term_voltage_limits.low;
			end
			{2'b00, `TAS_IDX_CM_LOW}: begin
				read_value = current_mon_limits.low;
			end
			{2'b00, `TAS_IDX_TV_HIGH}: begin
				read_value = term_voltage_limits.high;
			end
			{2'b00, `TAS_IDX_CM_HIGH}: begin
				read_value = current_mon_limits.high;
			end
			{2'b00, `TAS_IDX_CPU_CFG_TWO}: begin
				read_value = cpu_link_config_two;
			end
			{2'b00, `TAS_IDX_OP_CPU}: begin
				read_value = op_point.cpu;
			end
			{2'b00, `TAS_IDX_OP_REMOTE_ONE}: begin
				read_value = op_point.remote_one;
			end
			{2'b00, `TAS_IDX_OP_LOCAL}: begin
				read_value = op_point.on_die;
			end
			{2'b00, `TAS_IDX_OP_REMOTE_TWO}: begin
				read_value = op_point.remote_two;
			end
			default: begin
				index_mapped = 1'b0;
			end
		endcase
		if (paddr[1:0] != 2'b00) begin
			index_mapped = 1'b0;
		end
	end

	// read data and error are latched in setup so the data outputs come from flops
	always_ff @(posedge mclk) begin
		if (rst) begin
			prdata             <= 32'h0000_0000;
			pslverr            <= 1'b0;
			read_snapshot      <= 8'h00;
			snapshot_is_status <= 1'b0;
		end else if (setup_phase) begin
			prdata             <= pwrite ? 32'h0000_0000 : {24'h00_0000, read_value};
			pslverr            <= !index_mapped;
			read_snapshot      <= read_value;
			snapshot_is_status <= !pwrite && is_index(reg_index, `TAS_IDX_STATUS_FOUR);
		end
	end

	always_comb begin
		status_clear = 8'h00;
		// only bits the reader actually saw may clear, so no event is lost
		if (access_done && snapshot_is_status) begin
			status_clear = read_snapshot;
		end
	end

	tas_window_check u_cm_window (
		.reading (current_monitor),
		.window  (current_mon_limits),
		.outside (current_mon_outside)
	);

	tas_window_check u_tv_window (
		.reading (termination_voltage),
		.window  (term_voltage_limits),
		.outside (term_voltage_outside)
	);

	always_comb begin
		status_cause = 8'h00;
		status_cause[`TAS_BIT_CPU3:`TAS_BIT_CPU1] = events.cpu_out_of_limit & cpu_active[3:1];
		status_cause[`TAS_BIT_CURRENT_MON]        = current_mon_outside;
		status_cause[`TAS_BIT_TERM_VOLT]          = term_voltage_outside;
	end

	tas_sticky_status u_status_four (
		.mclk       (mclk),
		.rst        (rst),
		.cause      (status_cause),
		.read_clear (status_clear),
		.status     (limit_event_status_four)
	);

	// masks stay writable under lock: they are not limit or config state
	always_ff @(posedge mclk) begin
		if (rst) begin
			alert_mask_three <= `TAS_RST_MASK;
			alert_mask_four  <= `TAS_RST_MASK;
		end else if (wr_en) begin
			if (is_index(reg_index, `TAS_IDX_MASK_THREE)) begin
				alert_mask_three <= pwdata[7:0];
			end
			if (is_index(reg_index, `TAS_IDX_MASK_FOUR)) begin
				alert_mask_four <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			term_voltage_limits.low  <= `TAS_RST_LOW_LIMIT;
			current_mon_limits.low   <= `TAS_RST_LOW_LIMIT;
			term_voltage_limits.high <= `TAS_RST_HIGH_LIMIT;
			current_mon_limits.high  <= `TAS_RST_HIGH_LIMIT;
		end else if (wr_allowed) begin
			if (is_index(reg_index, `TAS_IDX_TV_LOW)) begin
				term_voltage_limits.low <= pwdata[7:0];
			end
			if (is_index(reg_index, `TAS_IDX_CM_LOW)) begin
				current_mon_limits.low <= pwdata[7:0];
			end
			if (is_index(reg_index, `TAS_IDX_TV_HIGH)) begin
				term_voltage_limits.high <= pwdata[7:0];
			end
			if (is_index(reg_index, `TAS_IDX_CM_HIGH)) begin
				current_mon_limits.high <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cpu_link_config_two <= `TAS_RST_CPU_CFG;
		end else if (wr_allowed && is_index(reg_index, `TAS_IDX_CPU_CFG_TWO)) begin
			cpu_link_config_two <= pwdata[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			thermal_limit_pin_prev <= 1'b0;
		end else begin
			thermal_limit_pin_prev <= thermal_limit_pin;
		end
	end

	// capture once per assertion, so the point holds the trip temperature
	assign thermal_limit_pin_rise = thermal_limit_pin && !thermal_limit_pin_prev;

	// hardware capture is not a bus write, so the lock does not stop it
	always_ff @(posedge mclk) begin
		if (rst) begin
			op_point.cpu        <= `TAS_RST_OP_CPU;
			op_point.remote_one <= `TAS_RST_OP_TEMP;
			op_point.on_die     <= `TAS_RST_OP_TEMP;
			op_point.remote_two <= `TAS_RST_OP_TEMP;
		end else begin
			if (wr_allowed && is_index(reg_index, `TAS_IDX_OP_CPU)) begin
				op_point.cpu <= pwdata[7:0];
			end
			if (thermal_limit_pin_rise && capture_enable.remote_one) begin
				op_point.remote_one <= remote_one_temp;
			end else if (wr_allowed && is_index(reg_index, `TAS_IDX_OP_REMOTE_ONE)) begin
				op_point.remote_one <= pwdata[7:0];
			end
			if (thermal_limit_pin_rise && capture_enable.on_die) begin
				op_point.on_die <= local_temp;
			end else if (wr_allowed && is_index(reg_index, `TAS_IDX_OP_LOCAL)) begin
				op_point.on_die <= pwdata[7:0];
			end
			if (thermal_limit_pin_rise && capture_enable.remote_two) begin
				op_point.remote_two <= remote_two_temp;
			end else if (wr_allowed && is_index(reg_index, `TAS_IDX_OP_REMOTE_TWO)) begin
				op_point.remote_two <= pwdata[7:0];
			end
		end
	end

	assign cpu_active = cpus_from_count(
		cpu_link_config_two[`TAS_FLD_CPU_COUNT_HI:`TAS_FLD_CPU_COUNT_LO]);

	always_ff @(posedge mclk) begin
		if (rst) begin
			cpu_poll_enable <= 4'h1;
			cpu_two_domains <= 4'h0;
		end else begin
			cpu_poll_enable <= cpu_active;
			cpu_two_domains <= {cpu_link_config_two[`TAS_BIT_DOM_CPU4],
				cpu_link_config_two[`TAS_BIT_DOM_CPU3],
				cpu_link_config_two[`TAS_BIT_DOM_CPU2], 1'b0};
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			target_temp  <= '0;
			target_valid <= 5'h00;
		end else begin
			target_temp  <= op_point;
			target_valid <= {cpu_dynamic_enable, fan_start_temperature_dynamic.remote_one,
				fan_start_temperature_dynamic.on_die, fan_start_temperature_dynamic.remote_two, 1'b0};
		end
	end

	// constant divide is a fixed multiplier tree; only the bypassed scale is known here
	function automatic logic [11:0] code_to_mv(input logic [7:0] code);
		logic [19:0] product;
		product = 20'(code) * 20'(`TAS_BYPASS_FULL_MV);
		return 12'(product / 20'(`TAS_CODE_FULL));
	endfunction

	always_ff @(posedge mclk) begin
		if (rst) begin
			term_voltage_mv       <= 12'h000;
			term_voltage_mv_valid <= 1'b0;
		end else begin
			term_voltage_mv       <= code_to_mv(termination_voltage);
			term_voltage_mv_valid <= term_voltage_bypass;
		end
	end

	// summary mask acts alone; individual bits silence the summary path only when every set status bit is masked
	assign alert_from_status = |(limit_event_status_four & ~alert_mask_four)
		&& !alert_mask_three[`TAS_BIT_M3_SUMMARY];

	assign alert_from_events =
		(events.cpu_zero_out_of_limit && !alert_mask_three[`TAS_BIT_M3_CPU0]) ||
		(events.data_error && !alert_mask_three[`TAS_BIT_M3_DATA]) ||
		(events.link_error && !alert_mask_three[`TAS_BIT_M3_LINK]) ||
		(events.overtemp && !alert_mask_three[`TAS_BIT_M3_OVERTEMP]);

	always_ff @(posedge mclk) begin
		if (rst) begin
			alert                <= 1'b0;
			out_of_limit_summary <= 1'b0;
		end else begin
			alert                <= alert_from_status || alert_from_events;
			out_of_limit_summary <= |limit_event_status_four;
		end
	end

endmodule

// >>> tb/tas_regs_properties.sv
// Purpose: port-level checks of the thermal alert register bank
// Assumes: byte address is four times the register index
// Notes: helper flops mirror the last accepted config write and capture
module tas_regs_properties (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic                  config_lock,
	input  tas_pkg::tas_events_s       events,
	input  tas_pkg::tas_byte_t         termination_voltage,
	input  wire logic                  term_voltage_bypass,
	input  wire logic                  thermal_limit_pin,
	input  tas_pkg::tas_channel_flags_s capture_enable,
	input  tas_pkg::tas_byte_t         remote_one_temp,
	input  wire logic                  alert,
	input  wire logic                  out_of_limit_summary,
	input  wire logic [3:0]            cpu_poll_enable,
	input  wire logic [3:0]            cpu_two_domains,
	input  tas_pkg::tas_op_points_s    target_temp,
	input  wire logic [11:0]           term_voltage_mv,
	input  wire logic                  term_voltage_mv_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	logic       cfg_wr;
	logic       cfg_wr_locked;
	logic       stat_rd;
	logic [7:0] cfg_seen;
	logic [7:0] cap_seen;
	assign cfg_wr        = psel && penable && pwrite && !config_lock && paddr == 12'h220;
	assign cfg_wr_locked = psel && penable && pwrite && config_lock && paddr == 12'h220;
	assign stat_rd       = psel && penable && !pwrite && paddr == 12'h204;
	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_seen <= 8'h00;
			cap_seen <= 8'h64;
		end else begin
			if (cfg_wr)
				cfg_seen <= pwdata[7:0];
			if ($rose(thermal_limit_pin) && capture_enable.remote_one)
				cap_seen <= remote_one_temp;
		end
	end
	// both read edges excluded: summary may lag status by one flop
	property p_status_sticky;
		out_of_limit_summary && !stat_rd && !$past(stat_rd) |=> out_of_limit_summary;
	endproperty
	a_status_sticky: assert property (p_status_sticky)
		else $error("summary dropped without a status read");
	property p_alert_idle;
		events == '0 ##1 (events == '0 && !out_of_limit_summary) |-> !alert;
	endproperty
	a_alert_idle: assert property (p_alert_idle)
		else $error("alert high with no cause");
	property p_poll_count;
		cfg_wr |=> ##[0:2] cpu_poll_enable == 4'((5'h02 << cfg_seen[7:6]) - 5'h01);
	endproperty
	a_poll_count: assert property (p_poll_count)
		else $error("poll enables do not follow cpu count");
	property p_domains;
		cfg_wr |=> ##[0:2] cpu_two_domains == {cfg_seen[3], cfg_seen[4], cfg_seen[5], 1'b0};
	endproperty
	a_domains: assert property (p_domains)
		else $error("domain flags do not follow config");
	property p_lock;
		cfg_wr_locked |=> ($stable(cpu_poll_enable) && $stable(cpu_two_domains)) [*3];
	endproperty
	a_lock: assert property (p_lock)
		else $error("locked config write took effect");
	property p_op_reset;
		$fell(rst) |-> ##[0:1] target_temp == 32'hfb646464;
	endproperty
	a_op_reset: assert property (p_op_reset)
		else $error("operating points not at reset values");
	property p_capture;
		$rose(thermal_limit_pin) && capture_enable.remote_one |=> ##[0:2] target_temp.remote_one == cap_seen;
	endproperty
	a_capture: assert property (p_capture)
		else $error("temperature not captured on thermal pin");
	property p_bypass_mv;
		(term_voltage_bypass && $stable(termination_voltage)) [*3] |->
			term_voltage_mv_valid && term_voltage_mv == 12'((32'(termination_voltage) * 32'd2250) / 32'd255);
	endproperty
	a_bypass_mv: assert property (p_bypass_mv)
		else $error("bypass voltage scale wrong");
endmodule

bind tas_regs tas_regs_properties u_props (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .config_lock,
	.events, .termination_voltage, .term_voltage_bypass, .thermal_limit_pin, .capture_enable, .remote_one_temp,
	.alert, .out_of_limit_summary, .cpu_poll_enable, .cpu_two_domains, .target_temp, .term_voltage_mv,
	.term_voltage_mv_valid);

// >>> tb/tas_far_model.sv
// Purpose: far-side sources: readings, cpu link events, thermal pin
// Assumes: readings already in register code, synchronous to mclk
// Notes: values change just after a rising edge, like a sampled converter
module tas_far_model (
	input  wire logic            mclk,
	output tas_pkg::tas_events_s events,
	output tas_pkg::tas_byte_t   current_monitor,
	output tas_pkg::tas_byte_t   termination_voltage,
	output tas_pkg::tas_byte_t   remote_one_temp,
	output logic                 thermal_limit_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		events = '0;
		current_monitor = 8'h20;
		termination_voltage = 8'h50;
		remote_one_temp = 8'h30;
		thermal_limit_pin = 1'b0;
	end
	task automatic apply(input tas_pkg::tas_events_s ev, input tas_pkg::tas_byte_t cm, input tas_pkg::tas_byte_t tv,
		input logic pin);
		@(posedge mclk);
		events <= ev;
		current_monitor <= cm;
		termination_voltage <= tv;
		thermal_limit_pin <= pin;
	endtask
	task automatic set_temp(input tas_pkg::tas_byte_t t);
		@(posedge mclk);
		remote_one_temp <= t;
	endtask
endmodule

// >>> tb/tb.sv
// Purpose: self-checking bench of the thermal alert register bank
// Assumes: zero-wait APB slave, far-side sources from the partner model
// Notes: outputs are sampled at the falling edge, away from updates
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                        mclk;
	logic                        rst;
	logic                        psel;
	logic                        penable;
	logic                        pwrite;
	logic [11:0]                 paddr;
	logic [31:0]                 pwdata;
	logic [31:0]                 prdata;
	logic                        pready;
	logic                        pslverr;
	logic                        config_lock;
	logic                        term_voltage_bypass;
	logic                        cpu_dynamic_enable;
	tas_pkg::tas_channel_flags_s capture_enable;
	tas_pkg::tas_channel_flags_s dyn_enable;
	tas_pkg::tas_events_s        events;
	tas_pkg::tas_byte_t          current_monitor;
	tas_pkg::tas_byte_t          termination_voltage;
	tas_pkg::tas_byte_t          remote_one_temp;
	logic                        thermal_limit_pin;
	logic                        alert;
	logic                        out_of_limit_summary;
	logic [3:0]                  cpu_poll_enable;
	logic [3:0]                  cpu_two_domains;
	tas_pkg::tas_op_points_s     target_temp;
	logic [4:0]                  target_valid;
	logic [11:0]                 term_voltage_mv;
	logic                        term_voltage_mv_valid;
	int                          bad_count;
	int                          n_compared;
	logic [31:0]                 rdat;
	logic                        rerr;
	localparam logic [7:0] reg_idx [12] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h8a, 8'h8b,
		8'h8c, 8'h8d};
	localparam logic [7:0] reg_rst [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'hfb, 8'h64,
		8'h64, 8'h64};

	tas_far_model far (.mclk, .events, .current_monitor, .termination_voltage, .remote_one_temp, .thermal_limit_pin);
	tas_regs DUT (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .config_lock,
		.events, .current_monitor, .termination_voltage, .term_voltage_bypass, .thermal_limit_pin, .capture_enable,
		.fan_start_temperature_dynamic(dyn_enable), .cpu_dynamic_enable, .remote_one_temp,
		.local_temp(remote_one_temp), .remote_two_temp(remote_one_temp), .alert, .out_of_limit_summary,
		.cpu_poll_enable, .cpu_two_domains, .target_temp,
		.target_valid, .term_voltage_mv, .term_voltage_mv_valid);

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			finish_test();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(what, rdat, {24'h000000, exp});
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask

	initial begin
		bad_count = 0;
		n_compared = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		config_lock = 1'b0;
		term_voltage_bypass = 1'b0;
		cpu_dynamic_enable = 1'b0;
		capture_enable = 3'b000;
		dyn_enable = 3'b000;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 12; i++)
			rchk("reset value", reg_idx[i], reg_rst[i]);
		chk("poll default", 32'(cpu_poll_enable), 32'h1);
		apb(1'b0, 8'h89, 8'h00);
		chk("unmapped error", 32'(rerr), 32'h1);
		$display("test reset done");
		config_lock <= 1'b1;
		apb(1'b1, 8'h84, 8'h55);
		apb(1'b1, 8'h88, 8'hc0);
		apb(1'b1, 8'h8b, 8'h11);
		rchk("locked limit", 8'h84, 8'h00);
		rchk("locked config", 8'h88, 8'h00);
		rchk("locked point", 8'h8b, 8'h64);
		config_lock <= 1'b0;
		apb(1'b1, 8'h85, 8'h10);
		apb(1'b1, 8'h86, 8'h90);
		apb(1'b1, 8'h88, 8'h40);
		settle(2);
		chk("poll two", 32'(cpu_poll_enable), 32'h3);
		apb(1'b1, 8'h88, 8'hf8);
		settle(2);
		chk("poll enable", 32'(cpu_poll_enable), 32'hf);
		chk("two domains", 32'(cpu_two_domains), 32'he);
		$display("test lock and config done");
		// low current, high voltage, three cpu readings out
		far.apply(7'h07, 8'h05, 8'ha0, 1'b0);
		settle(3);
		rchk("status set", 8'h81, 8'hf8);
		rchk("status kept", 8'h81, 8'hf8);
		far.apply(7'h00, 8'h20, 8'h50, 1'b0);
		settle(3);
		rchk("status last", 8'h81, 8'hf8);
		rchk("status cleared", 8'h81, 8'h00);
		$display("test status done");
		far.apply(7'h07, 8'h05, 8'ha0, 1'b0);
		settle(3);
		chk("alert raised", 32'(alert), 32'h1);
		for (int j = 3; j < 8; j++) begin
			apb(1'b1, 8'h83, ~(8'h01 << j));
			settle(2);
			chk("alert one unmasked", 32'(alert), 32'h1);
		end
		apb(1'b1, 8'h83, 8'hff);
		settle(2);
		chk("alert all masked", 32'(alert), 32'h0);
		apb(1'b1, 8'h83, 8'h00);
		apb(1'b1, 8'h82, 8'h80);
		settle(2);
		chk("alert summary masked", 32'(alert), 32'h0);
		apb(1'b1, 8'h82, 8'h00);
		far.apply(7'h00, 8'h20, 8'h50, 1'b0);
		settle(2);
		apb(1'b0, 8'h81, 8'h00);
		settle(3);
		chk("alert gone", 32'(alert), 32'h0);
		for (int k = 0; k < 4; k++) begin
			far.apply(7'h40 >> k, 8'h20, 8'h50, 1'b0);
			settle(2);
			chk("event alert", 32'(alert), 32'h1);
			apb(1'b1, 8'h82, 8'h01 << k);
			settle(2);
			chk("event masked", 32'(alert), 32'h0);
			apb(1'b1, 8'h82, 8'h00);
		end
		$display("test alert done");
		far.set_temp(8'h55);
		config_lock <= 1'b1;
		capture_enable <= 3'b111;
		far.apply(7'h00, 8'h20, 8'h50, 1'b1);
		settle(3);
		rchk("captured point", 8'h8b, 8'h55);
		rchk("captured remote two", 8'h8d, 8'h55);
		chk("captured target", 32'(target_temp.remote_one), 32'h55);
		far.apply(7'h00, 8'h20, 8'h50, 1'b0);
		config_lock <= 1'b0;
		dyn_enable <= 3'b111;
		cpu_dynamic_enable <= 1'b1;
		apb(1'b1, 8'h8c, 8'h40);
		settle(2);
		chk("local target", 32'(target_temp.on_die), 32'h40);
		chk("target valid", 32'(target_valid), 32'h1e);
		@(posedge mclk);
		term_voltage_bypass <= 1'b1;
		settle(3);
		chk("bypass mv", 32'(term_voltage_mv), (32'h50 * 32'd2250) / 32'd255);
		chk("bypass valid", 32'(term_voltage_mv_valid), 32'h1);
		$display("test capture and scale done");
		finish_test();
	end
endmodule
